//--- bench/hbsc_host_model.sv
// Host-side serial master model that shifts frames into the block and captures its status.
`timescale 1ns/1ps
module hbsc_host_model (
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe_n,
  output logic      o_sclk,
  output logic      o_frame_select_n,
  output logic      o_sdi
);
  logic last;
  logic line;
  // A released output reads as the inverse of its last driven level, so a late enable cannot pass by luck.
  assign line = i_sdo_oe_n ? ~last : i_sdo;
  always @(i_sdo or i_sdo_oe_n) if (!i_sdo_oe_n) last = i_sdo;
  initial begin
    last = 1'b0;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_frame_select_n = 1'b1;
  end
  task automatic xfer(input logic [31:0] c, input int n, output logic pre, output logic [15:0] st);
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    #100 o_frame_select_n = 1'b0;
    #100 pre = line;
    st = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b1;
      o_sdi = c[i];
      #80 st = {st[14:0], line};
      o_sclk = 1'b0;
      #80;
    end
    o_sdi = 1'b0;
    #100 o_frame_select_n = 1'b1;
    #100;
  endtask
endmodule

//--- bench/tb_half_bridge_serial_control.sv
// Self-checking bench of the half-bridge serial control block against a behavioural model.
`timescale 1ns/1ps
module tb_half_bridge_serial_control;
  import hbsc_pkg::*;
  logic                   i_mclk, i_rst_n, i_enable, i_sclk, i_frame_select_n, i_sdi;
  logic                   o_sdo, o_sdo_oe_n, o_sleep, i_thermal_shutdown, m_grp, pre, i_supply_fault, i_thermal_warn;
  logic [NUM_BRIDGES-1:0] i_overcurrent, i_underload, o_high_side_on, o_low_side_on, m_en, m_dir;
  logic [31:0]            cmd;
  logic [15:0]            st;
  int                     err_total, n_checks;

  hbsc_core u_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_enable(i_enable), .i_sclk(i_sclk),
    .i_frame_select_n(i_frame_select_n), .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n),
    .i_overcurrent(i_overcurrent), .i_underload(i_underload), .i_supply_fault(i_supply_fault),
    .i_thermal_warn(i_thermal_warn), .i_thermal_shutdown(i_thermal_shutdown),
    .o_high_side_on(o_high_side_on), .o_low_side_on(o_low_side_on), .o_sleep(o_sleep)
  );
  hbsc_host_model u_host (
    .i_sdo(o_sdo), .i_sdo_oe_n(o_sdo_oe_n), .o_sclk(i_sclk),
    .o_frame_select_n(i_frame_select_n), .o_sdi(i_sdi)
  );

  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  task automatic results;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input logic [31:0] msk);
    n_checks++;
    if (((exp ^ got) & msk) !== 32'h0) begin
      err_total++;
      $display("[FAIL] %0t expected %h got %h", $time, exp & msk, got & msk);
    end
  endtask

  task automatic chk_drv;
    chk({12'h0, m_en & m_dir, m_en & ~m_dir}, {12'h0, o_high_side_on, o_low_side_on}, 32'hFFFFF);
  endtask

  // Only the overcurrent flag is modelled; the other fault flags are expected as zero.
  function automatic logic [15:0] exp_st(input logic oc);
    logic [NUM_BRIDGES-1:0] d;
    d = m_en & m_dir;
    if (m_grp) exp_st = {oc, 4'h0, m_en[9:6], 2'b00, d[9:6], 1'b0};
    else exp_st = {oc, 2'b00, m_en[5:0], d[5:0], 1'b0};
  endfunction

  task automatic frame(input logic [31:0] c, input int n, input logic ok, input logic [15:0] msk,
                       input logic oc, input logic p);
    u_host.xfer(c, n, pre, st);
    if (msk !== 16'h0) begin
      chk(32'(p), 32'(pre), 32'h1);
      chk(32'(exp_st(oc)), 32'(st), 32'(msk));
    end
    chk(32'h1, 32'(o_sdo_oe_n), 32'h1);
    if (ok && c[14]) begin
      m_en[9:6] = c[10:7];
      m_dir[9:6] = c[4:1];
    end else if (ok) begin
      m_en[5:0] = c[12:7];
      m_dir[5:0] = c[6:1];
    end
    if (ok) m_grp = c[14];
    repeat (12) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask

  task automatic wake;
    @(posedge i_mclk);
    i_enable <= 1'b1;
    for (int w = 0; w < 20 && o_sleep !== 1'b0; w++) @(negedge i_mclk);
    repeat (8) @(negedge i_mclk);
    chk(32'h0, 32'(o_sleep), 32'h1);
    if (o_sleep !== 1'b0) results();
  endtask

  initial begin
    #2ms;
    err_total++;
    results();
  end

  initial begin
    void'($urandom(32'h67c6));
    {i_rst_n, i_enable, i_thermal_shutdown, i_overcurrent, i_underload, i_supply_fault, i_thermal_warn} = '0;
    {m_en, m_dir, m_grp, err_total, n_checks} = '0;
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(negedge i_mclk);
    chk_drv;
    chk(32'h1, 32'(o_sleep), 32'h1);
    wake;
    for (int k = 0; k < 6; k++) begin
      cmd = $urandom;
      cmd[14] = k[0];
      frame(cmd, 16, 1'b1, 16'hFFFF, 1'b0, 1'b0);
      chk_drv;
    end
    frame($urandom, 15, 1'b0, 16'h0, 1'b0, 1'b0);
    frame($urandom, 17, 1'b0, 16'h0, 1'b0, 1'b0);
    chk_drv;
    frame($urandom, 32, 1'b1, 16'h0, 1'b0, 1'b0);
    chk_drv;
    frame(32'h0080, 16, 1'b1, 16'hFFFF, 1'b0, 1'b0);
    @(posedge i_mclk);
    i_overcurrent <= 10'h001;
    i_thermal_shutdown <= 1'b1;
    repeat (8) @(posedge i_mclk);
    i_overcurrent <= 10'h000;
    i_thermal_shutdown <= 1'b0;
    repeat (8) @(posedge i_mclk);
    frame(32'h0000, 16, 1'b1, 16'h8000, 1'b1, 1'b1);
    frame(32'h8000, 16, 1'b1, 16'h8000, 1'b1, 1'b1);
    frame(32'h0000, 16, 1'b1, 16'h8000, 1'b0, 1'b0);
    cmd = $urandom;
    cmd[14] = 1'b1;
    frame(cmd, 16, 1'b1, 16'h0, 1'b0, 1'b0);
    cmd = $urandom | 32'h8000;
    cmd[14] = 1'b0;
    frame(cmd, 16, 1'b1, 16'h0, 1'b0, 1'b0);
    chk_drv;
    frame(32'h0781, 16, 1'b1, 16'h0, 1'b0, 1'b0);
    chk_drv;
    @(posedge i_mclk);
    i_supply_fault <= 1'b1;
    repeat (8) @(negedge i_mclk);
    chk(32'h0, {12'h0, o_high_side_on, o_low_side_on}, 32'hFFFFF);
    frame(32'h0781, 16, 1'b1, 16'h0, 1'b0, 1'b0);
    chk(32'h4000, 32'(st), 32'h4000);
    @(posedge i_mclk);
    i_supply_fault <= 1'b0;
    repeat (8) @(negedge i_mclk);
    chk_drv;
    frame(32'h2781, 16, 1'b1, 16'h0, 1'b0, 1'b0);
    @(posedge i_mclk);
    i_underload <= 10'h002;
    repeat (8) @(posedge i_mclk);
    i_underload <= 10'h000;
    repeat (8) @(negedge i_mclk);
    m_en[1] = 1'b0;
    chk_drv;
    frame(32'hA781, 16, 1'b1, 16'h0, 1'b0, 1'b0);
    chk(32'h2000, 32'(st), 32'h2000);
    chk_drv;
    @(posedge i_mclk);
    i_thermal_warn <= 1'b1;
    repeat (4) @(negedge i_mclk);
    frame(32'h4000, 16, 1'b1, 16'hFFFF, 1'b0, 1'b0);
    frame(32'h4000, 16, 1'b1, 16'hFFFE, 1'b0, 1'b0);
    chk(32'h1, 32'(st), 32'h1);
    @(posedge i_mclk);
    i_thermal_warn <= 1'b0;
    i_enable <= 1'b0;
    repeat (8) @(negedge i_mclk);
    {m_en, m_dir, m_grp} = '0;
    chk(32'h1, 32'(o_sleep), 32'h1);
    chk_drv;
    frame(32'h07FE, 16, 1'b0, 16'h0, 1'b0, 1'b0);
    wake;
    chk_drv;
    frame($urandom, 16, 1'b1, 16'hFFFF, 1'b0, 1'b0);
    chk_drv;
    results();
  end
endmodule

//--- src/hbsc_core.sv
// Serial command and status logic of the ten-channel half-bridge driver.
`timescale 1ns/1ps
module hbsc_core
  import hbsc_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_enable,
  input  wire logic                   i_sclk,
  input  wire logic                   i_frame_select_n,
  input  wire logic                   i_sdi,
  output logic                        o_sdo,
  output logic                        o_sdo_oe_n,
  input  wire logic [NUM_BRIDGES-1:0] i_overcurrent,
  input  wire logic [NUM_BRIDGES-1:0] i_underload,
  input  wire logic                   i_supply_fault,
  input  wire logic                   i_thermal_warn,
  input  wire logic                   i_thermal_shutdown,
  output logic [NUM_BRIDGES-1:0]      o_high_side_on,
  output logic [NUM_BRIDGES-1:0]      o_low_side_on,
  output logic                        o_sleep
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] en_sync;
    logic [SYNC_STAGES-1:0] fsel_sync;
    logic [2:0]             done_sync;
    logic [NUM_BRIDGES-1:0] oc_s1;
    logic [NUM_BRIDGES-1:0] oc_s2;
    logic [NUM_BRIDGES-1:0] uld_s1;
    logic [NUM_BRIDGES-1:0] uld_s2;
    logic [2:0]             misc_s1;
    logic [2:0]             misc_s2;
    logic [15:0]            cmd_hi;
    logic [15:0]            cmd_lo;
    logic                   ov_lock;
    logic                   last_group;
    logic [NUM_BRIDGES-1:0] oc_latch;
    logic [NUM_BRIDGES-1:0] uld_latch;
    logic                   tsd_latch;
    logic [15:0]            status_hold;
    logic                   tsd_hold;
    logic [NUM_BRIDGES-1:0] hs_on;
    logic [NUM_BRIDGES-1:0] ls_on;
  } hbsc_main_s;

  typedef struct packed {
    logic [15:0] sr;
    logic [3:0]  cnt;
    logic        seen;
  } hbsc_rx_s;

  typedef struct packed {
    logic [15:0] sr;
    logic        first;
  } hbsc_tx_s;

  typedef struct packed {
    logic [15:0] word;
    logic        err;
    logic        done_tgl;
  } hbsc_cap_s;

  hbsc_main_s             st;
  hbsc_main_s             next_st;
  hbsc_rx_s               rx;
  hbsc_rx_s               next_rx;
  hbsc_tx_s               tx;
  hbsc_tx_s               next_tx;
  hbsc_cap_s              cap;
  logic                   link_clr;
  logic                   done_pulse;
  logic                   enabled;
  logic                   commit;
  logic                   clear_req;
  logic [NUM_BRIDGES-1:0] clr_mask;
  logic [NUM_BRIDGES-1:0] en_bits;
  logic [NUM_BRIDGES-1:0] dir_bits;
  logic [NUM_BRIDGES-1:0] uld_en;
  logic [NUM_BRIDGES-1:0] allow;
  logic                   psf;
  logic                   tw;
  logic                   tsd;

  function automatic logic [NUM_BRIDGES-1:0] group_mask(input logic grp);
    logic [NUM_BRIDGES-1:0] m;
    m = '0;
    if (grp) begin
      m[UP_FIRST +: UP_COUNT] = '1;
    end else begin
      m[LO_FIRST +: LO_COUNT] = '1;
    end
    return m;
  endfunction

  // Builds the status word of one group from the live bridge and fault state.
  function automatic logic [15:0] status_word(
    input logic                   grp,
    input logic [NUM_BRIDGES-1:0] state,
    input logic [NUM_BRIDGES-1:0] dir,
    input logic [NUM_BRIDGES-1:0] oc,
    input logic [NUM_BRIDGES-1:0] uld,
    input logic                   supply,
    input logic                   warn
  );
    logic [15:0]            w;
    logic [NUM_BRIDGES-1:0] m;
    w         = '0;
    m         = group_mask(grp);
    w[ST_OC]  = |(oc & m);
    w[ST_PSF] = supply;
    w[ST_ULD] = |(uld & m);
    if (grp) begin
      w[EN_LSB +: UP_COUNT]  = state[UP_FIRST +: UP_COUNT];
      w[DIR_LSB +: UP_COUNT] = dir[UP_FIRST +: UP_COUNT];
      w[ST_TW]               = warn;
    end else begin
      w[EN_LSB +: LO_COUNT]  = state[LO_FIRST +: LO_COUNT];
      w[DIR_LSB +: LO_COUNT] = dir[LO_FIRST +: LO_COUNT];
    end
    return w;
  endfunction

  // Link side. The frame select signal itself clears the link logic, so
  // nothing relies on serial clock edges outside a frame.
  assign link_clr = i_frame_select_n | ~i_rst_n;

  always_comb begin
    next_rx      = rx;
    next_rx.sr   = {rx.sr[14:0], i_sdi};       // R8
    next_rx.cnt  = rx.cnt + 4'h1;              // R4
    next_rx.seen = 1'b1;
  end

  always_ff @(negedge i_sclk or posedge link_clr) begin
    if (link_clr) begin
      rx <= '0;
    end else begin
      rx <= next_rx;                           // R9
    end
  end

  // The status word is held still in the main domain while a frame runs,
  // so the link side may load it without further crossing logic.
  always_comb begin
    next_tx       = tx;
    next_tx.first = 1'b1;
    if (!tx.first) begin
      next_tx.sr = st.status_hold;             // R7
    end else begin
      next_tx.sr = {tx.sr[14:0], 1'b0};        // R10
    end
  end

  always_ff @(posedge i_sclk or posedge link_clr) begin
    if (link_clr) begin
      tx <= '0;
    end else begin
      tx <= next_tx;
    end
  end

  // The rising frame select edge captures the frame; the toggle hands it over.
  always_ff @(posedge i_frame_select_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cap <= '0;
    end else begin
      cap.word     <= rx.sr;
      cap.err      <= !rx.seen || (rx.cnt != 4'h0); // R25
      cap.done_tgl <= ~cap.done_tgl;
    end
  end

  assign o_sdo      = tx.first ? tx.sr[15] : st.tsd_hold;     // R6 R7
  assign o_sdo_oe_n = i_frame_select_n | ~st.en_sync[1];      // R11

  // Main domain.
  assign enabled    = st.en_sync[1];
  assign done_pulse = st.done_sync[2] ^ st.done_sync[1];
  assign commit     = done_pulse && enabled && !cap.err;     // R1 R12 R13
  assign clear_req  = commit && cap.word[BIT_CLEAR];
  assign clr_mask   = clear_req ? group_mask(cap.word[BIT_GROUP]) : '0; // R18
  assign psf        = st.misc_s2[2];
  assign tw         = st.misc_s2[1];
  assign tsd        = st.misc_s2[0];

  // R14 R15
  assign en_bits  = {st.cmd_hi[EN_LSB +: UP_COUNT], st.cmd_lo[EN_LSB +: LO_COUNT]};
  assign dir_bits = {st.cmd_hi[DIR_LSB +: UP_COUNT], st.cmd_lo[DIR_LSB +: LO_COUNT]};
  assign uld_en   = {{UP_COUNT{st.cmd_hi[BIT_ULD_EN]}}, {LO_COUNT{st.cmd_lo[BIT_ULD_EN]}}}; // R19

  // A latched overcurrent, or a latched underload with shutdown enabled, keeps its bridge off until cleared; a latched thermal fault keeps every bridge off. R20 R22
  assign allow = en_bits & ~st.oc_latch & ~(st.uld_latch & uld_en)
               & ~{NUM_BRIDGES{st.tsd_latch | (st.ov_lock & psf)}};

  always_comb begin
    next_st              = st;
    next_st.en_sync      = {st.en_sync[0], i_enable};
    next_st.fsel_sync    = {st.fsel_sync[0], i_frame_select_n};
    next_st.done_sync    = {st.done_sync[1:0], cap.done_tgl};
    next_st.oc_s1        = i_overcurrent;
    next_st.oc_s2        = st.oc_s1;
    next_st.uld_s1       = i_underload;
    next_st.uld_s2       = st.uld_s1;
    next_st.misc_s1      = {i_supply_fault, i_thermal_warn, i_thermal_shutdown};
    next_st.misc_s2      = st.misc_s1;
    // A fault arriving with the clear stays latched. R22
    next_st.oc_latch     = (st.oc_latch & ~clr_mask) | st.oc_s2;
    // Underload only counts on a driven bridge; an idle output carries no load current.
    next_st.uld_latch    = (st.uld_latch & ~clr_mask) | (st.uld_s2 & (st.hs_on | st.ls_on));
    next_st.tsd_latch    = (st.tsd_latch & ~clear_req) | tsd;
    if (commit) begin
      if (cap.word[BIT_GROUP]) begin
        next_st.cmd_hi = cap.word;             // R26
      end else begin
        next_st.cmd_lo = cap.word;             // R26
      end
      next_st.ov_lock    = cap.word[BIT_OV_LOCK]; // R20
      next_st.last_group = cap.word[BIT_GROUP];
    end
    next_st.hs_on = allow & dir_bits;          // R16 R17
    next_st.ls_on = allow & ~dir_bits;         // R16 R17
    // Status is refreshed only between frames so the link sees a still word.
    if (st.fsel_sync[1]) begin
      next_st.status_hold = status_word(st.last_group, st.hs_on | st.ls_on, st.hs_on, // R23 R24
                                        st.oc_latch, st.uld_latch, psf, tw);
      next_st.tsd_hold    = st.tsd_latch;
    end
    if (!enabled) begin                        // R3
      next_st.cmd_hi      = CMD_RESET;
      next_st.cmd_lo      = CMD_RESET;
      next_st.ov_lock     = 1'b0;
      next_st.last_group  = 1'b0;
      next_st.oc_latch    = '0;
      next_st.uld_latch   = '0;
      next_st.tsd_latch   = 1'b0;
      next_st.hs_on       = '0;
      next_st.ls_on       = '0;
      next_st.status_hold = '0;
      next_st.tsd_hold    = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st           <= '0;                      // R21
      st.fsel_sync <= '1;
    end else begin
      st <= next_st;                           // R2
    end
  end

  assign o_high_side_on = st.hs_on;
  assign o_low_side_on  = st.ls_on;
  assign o_sleep        = ~enabled;

  a_sleep_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R3
    !enabled |=> st.cmd_hi == '0 && st.cmd_lo == '0 && o_high_side_on == '0 && o_low_side_on == '0)
    else $error("Sleep did not clear commands and drivers.");

  a_frame_ignored: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R1
    done_pulse && !enabled |=> st.cmd_hi == '0 && st.cmd_lo == '0 && !st.last_group)
    else $error("Frame accepted while disabled.");

  a_commit_word: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R12
    commit |=> (cap.word[BIT_GROUP] ? st.cmd_hi : st.cmd_lo) == $past(cap.word))
    else $error("Clean frame not stored.");

  a_error_keeps: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R13
    done_pulse && enabled && cap.err |=> $stable(st.cmd_hi) && $stable(st.cmd_lo) && $stable(st.ov_lock))
    else $error("Errored frame changed command data.");

  a_group_status: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R23
    commit ##1 enabled |-> st.last_group == $past(cap.word[BIT_GROUP]))
    else $error("Status group not taken from last frame.");

  a_hiz_output: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R16
    !st.cmd_lo[EN_LSB] |=> !o_high_side_on[0] && !o_low_side_on[0])
    else $error("Disabled bridge still driven.");

  a_no_shoot: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R17
    (o_high_side_on & o_low_side_on) == '0)
    else $error("Both switches of a bridge on.");

  a_lockout_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R20
    st.ov_lock && psf |=> o_high_side_on == '0 && o_low_side_on == '0)
    else $error("Overvoltage lockout left outputs on.");

  a_clear_lower: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R18
    clear_req && !cap.word[BIT_GROUP] && st.oc_s2 == '0 |=> st.oc_latch[LO_FIRST +: LO_COUNT] == '0)
    else $error("Status clear did not drop lower group faults.");

  a_dir_forced: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R24
    !st.last_group |-> ##1 (st.status_hold[DIR_LSB +: LO_COUNT] & ~st.status_hold[EN_LSB +: LO_COUNT]) == '0)
    else $error("Direction reported for an off bridge.");

  // The next five checks guard the fault latches, whose clear and set may meet in one cycle.
  a_uld_shutdown: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R19
    (st.uld_latch & uld_en) != '0 |=> ((o_high_side_on | o_low_side_on) & $past(st.uld_latch & uld_en)) == '0)
    else $error("Underload shutdown left a bridge driven.");

  a_fault_blocks: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R22
    st.oc_latch != '0 |=> ((o_high_side_on | o_low_side_on) & $past(st.oc_latch)) == '0)
    else $error("Latched overcurrent left a bridge driven.");

  a_tsd_cleared: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R22
    clear_req && !tsd |=> !st.tsd_latch)
    else $error("Status clear kept a gone thermal fault.");

  a_clear_upper: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R18
    clear_req && cap.word[BIT_GROUP] && st.oc_s2 == '0 |=> st.oc_latch[UP_FIRST +: UP_COUNT] == '0)
    else $error("Status clear did not drop upper group faults.");

  a_clear_scoped: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R18
    clear_req && !cap.word[BIT_GROUP]
      |=> ($past(st.oc_latch[UP_FIRST +: UP_COUNT]) & ~st.oc_latch[UP_FIRST +: UP_COUNT]) == '0)
    else $error("Status clear reached the other group.");

  a_drive_enabled: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R16
    en_bits != '1 |=> ((o_high_side_on | o_low_side_on) & ~$past(en_bits)) == '0)
    else $error("Bridge driven without its enable bit.");

  // A refresh during a frame would let the link shift a torn status word.
  a_status_frozen: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R7
    !st.fsel_sync[1] && enabled |=> $stable(st.status_hold) && $stable(st.tsd_hold))
    else $error("Status changed while a frame was running.");

  a_dir_upper: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R24
    st.last_group |-> ##1 (st.status_hold[DIR_LSB +: UP_COUNT] & ~st.status_hold[EN_LSB +: UP_COUNT]) == '0)
    else $error("Direction reported for an off upper bridge.");

  // The remaining checks but a_lock_stored cover sleep and wake, when every stored bit must read zero.
  a_asleep_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R1
    !enabled |-> o_sdo_oe_n)
    else $error("Serial output driven while asleep.");

  a_lock_stored: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R20
    commit |=> st.ov_lock == $past(cap.word[BIT_OV_LOCK]))
    else $error("Lockout enable not taken from the frame.");

  a_wake_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R21
    $rose(enabled) |-> st.cmd_hi == '0 && st.cmd_lo == '0 && !st.ov_lock)
    else $error("Command word not zero on wake.");

  a_sleep_status: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R3
    !enabled |=> st.status_hold == '0 && !st.tsd_hold && !st.tsd_latch && st.oc_latch == '0)
    else $error("Sleep did not clear the status.");

endmodule

//--- src/hbsc_pkg.sv
// Constants shared by the half-bridge serial control block.
// Summary of operation
// R1: Serial frames are ignored while the chip enable input is low.
// R2: After enable rises and reset completes, serial programming is accepted.
// R3: Enable falling clears all command and status state and turns bridges off.
// R4: Each transfer is a 16-bit full-duplex frame, command in, status out.
// R5: Host holds serial clock and data low before lowering frame select.
// R6: Frame select low starts a frame; output shows thermal pseudo-bit at once.
// R7: Pseudo-bit stays until first rising clock edge, then the status word follows.
// R8: Host shifts commands on rising edges, MSB first; device samples on falling.
// R9: Serial input is sampled on every falling clock edge.
// R10: Status shifts out on rising edges, MSB first, starting with overcurrent.
// R11: Frame select high ends the frame and releases the serial output.
// R12: A clean frame end moves the last 16 received bits into the command word.
// R13: A frame error discards the frame and keeps previous command data.
// R14: Group select 1 maps enables to bits 10:7 and directions to 4:1.
// R15: Group select 0 maps enables to bits 12:7 and directions to 6:1.
// R16: Enable bit 1 drives the half-bridge; 0 leaves it high impedance.
// R17: Direction 0 turns low side on; 1 turns high side on.
// R18: Bit 15 clears the status of the group selected in that frame.
// R19: Bit 13 enables per-bridge underload shutdown for the selected group.
// R20: Bit 0 enables global supply overvoltage lockout of all outputs.
// R21: Reset sets every stored command bit to zero.
// R22: Status clear drops latched faults; outputs return only if fault is gone.
// R23: Returned status belongs to the group chosen by the previous frame.
// R24: Reported direction is zero whenever the bridge output state is zero.
// R25: Frame error when the falling-edge count is zero or not a multiple of 16.
// R26: Status clear frames still store their enable and direction bits.
package hbsc_pkg;
  localparam int          FRAME_BITS  = 16;
  localparam int          NUM_BRIDGES = 10;
  localparam logic [15:0] CMD_RESET   = 16'h0000;
  // Command word fields.
  localparam int BIT_CLEAR   = 15;
  localparam int BIT_GROUP   = 14;
  localparam int BIT_ULD_EN  = 13;
  localparam int BIT_OV_LOCK = 0;
  localparam int EN_LSB      = 7;
  localparam int DIR_LSB     = 1;
  // Group layout: upper group is bridges 10..7, lower group bridges 6..1.
  localparam int UP_FIRST    = 6;
  localparam int UP_COUNT    = 4;
  localparam int LO_FIRST    = 0;
  localparam int LO_COUNT    = 6;
  // Status word fields.
  localparam int ST_OC       = 15;
  localparam int ST_PSF      = 14;
  localparam int ST_ULD      = 13;
  localparam int ST_TW       = 0;
  localparam int SYNC_STAGES = 2;
endpackage
